// ==== logic/rlc_pkg.sv ====
// Constants, register map and state codes for the rotate-left-through-carry unit
package rlc_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_INSTR     = 8'h04;
    localparam logic [7:0]  REG_WREG      = 8'h08;
    localparam logic [7:0]  REG_STATUS    = 8'h0c;
    localparam logic [7:0]  REG_BANK      = 8'h10;
    localparam logic [7:0]  REG_INDEX     = 8'h14;
    localparam logic [7:0]  REG_MEM_ADDR  = 8'h18;
    localparam logic [7:0]  REG_MEM_DATA  = 8'h1c;
    localparam logic [7:0]  REG_STATE     = 8'h20;

    // ************************************************************
    // Instruction pattern and fields
    // ************************************************************
    localparam logic [15:0] OPC_MASK      = 16'hfc00;
    localparam logic [15:0] OPC_MATCH     = 16'h3400;
    localparam int          DEST_BIT      = 9;
    localparam int          ACC_BIT       = 8;
    localparam logic [7:0]  IDX_LIMIT     = 8'h5f;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int          STS_C         = 0;
    localparam int          STS_Z         = 2;
    localparam int          STS_N         = 4;
    localparam logic [7:0]  FLAG_MASK     = 8'h15;
    localparam int          CTRL_EXT      = 0;
    localparam int          STATE_BUSY    = 0;
    localparam int          STATE_BADOP   = 1;
    localparam int          STATE_OVR     = 2;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [15:0] RST_INSTR     = 16'h0000;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;

    // ************************************************************
    // Bus responses
    // ************************************************************
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_DECERR   = 2'b11;

    // ************************************************************
    // Instruction cycle phases
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_DECODE  = 3'b001,
        ST_READ    = 3'b011,
        ST_PROCESS = 3'b010,
        ST_WRITE   = 3'b110
    } state_type;

endpackage

// ==== logic/rotate_left_via_carry_instr.sv ====
// Rotate-left-through-carry execution unit with AXI4-Lite register access
// Operation
// - Accept only opcodes whose top six bits are 001101; d, a, f follow.
// - Shift operand left; bit 7 goes to carry, old carry to bit 0.
// - Destination bit 0 writes accumulator; 1 writes back to source byte.
// - Access bit 0 uses quick-access bank; 1 uses bank select register.
// - Extended set, access bit 0, address up to 95: indexed literal offset.
// - Only carry, negative and zero flags change.
// - One word, one cycle of four phases: decode, read, process, write.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module rotate_left_via_carry_instr
    import rlc_pkg::*;
#(
    parameter int         ADDR_W       = 12,
    parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i
);

    localparam int BANK_W = ADDR_W - 8;
    localparam int DEPTH  = 2 ** ADDR_W;

    state_type               state;
    logic [15:0]             instr;
    logic [ADDR_W-1:0]       ea;
    logic                    dest;
    logic [7:0]              operand;
    logic [7:0]              result;
    logic                    ext_en;
    logic [7:0]              wreg;
    logic [7:0]              status;
    logic [BANK_W-1:0]       bank_sel;
    logic [ADDR_W-1:0]       index_base;
    logic [ADDR_W-1:0]       mem_addr;
    logic [7:0]              mem [DEPTH];
    logic                    bad_op;
    logic                    overrun;
    logic                    aw_hold;
    logic                    w_hold;
    logic [7:0]              awaddr_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic                    wr_fire;
    logic                    idle;
    logic                    start;
    logic                    opcode_ok;
    logic [31:0]             rd_word;
    logic                    rd_ok;

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] v;
        v = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return v;
    endfunction

    function automatic logic reg_mapped(input logic [7:0] addr);
        return addr == REG_CTRL || addr == REG_INSTR || addr == REG_WREG
            || addr == REG_STATUS || addr == REG_BANK || addr == REG_INDEX
            || addr == REG_MEM_ADDR || addr == REG_MEM_DATA || addr == REG_STATE;
    endfunction

    function automatic logic [ADDR_W-1:0] eff_addr(input logic [7:0]        f,
                                                   input logic              acc,
                                                   input logic              ext,
                                                   input logic [BANK_W-1:0] bsel,
                                                   input logic [ADDR_W-1:0] idx);
        if (!acc && ext && f <= IDX_LIMIT) begin
            return ADDR_W'(idx + ADDR_W'(f));
        end else if (acc) begin
            return {bsel, f};
        end else if (f < ACCESS_SPLIT) begin
            return {{BANK_W{1'b0}}, f};
        end
        return {{BANK_W{1'b1}}, f};
    endfunction

    function automatic logic wr_sel(input logic       fire,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
        return fire && addr == target;
    endfunction

    assign wr_fire   = aw_hold && w_hold && !s_axi_bvalid_o;
    assign idle      = state == ST_IDLE;
    assign start     = wr_sel(wr_fire, awaddr_q, REG_INSTR) && idle;
    assign opcode_ok = (instr & OPC_MASK) == OPC_MATCH;

    // ************************************************************
    // AXI4-Lite write channels
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            aw_hold         <= 1'b0;
            w_hold          <= 1'b0;
            awaddr_q        <= RST_BYTE;
            wdata_q         <= RST_WORD;
            wstrb_q         <= 4'h0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold         <= 1'b1;
                awaddr_q        <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold         <= 1'b1;
                wdata_q        <= s_axi_wdata_i;
                wstrb_q        <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o  <= 1'b0;
                aw_hold         <= 1'b0;
                w_hold          <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channels
    // ************************************************************
    always_comb begin
        rd_word = RST_WORD;
        rd_ok   = reg_mapped(s_axi_araddr_i);
        unique case (s_axi_araddr_i)
            REG_CTRL:     rd_word[CTRL_EXT] = ext_en;
            REG_INSTR:    rd_word[15:0] = instr;
            REG_WREG:     rd_word[7:0] = wreg;
            REG_STATUS:   rd_word[7:0] = status;
            REG_BANK:     rd_word[BANK_W-1:0] = bank_sel;
            REG_INDEX:    rd_word[ADDR_W-1:0] = index_base;
            REG_MEM_ADDR: rd_word[ADDR_W-1:0] = mem_addr;
            REG_MEM_DATA: rd_word[7:0] = mem[mem_addr];
            REG_STATE:    rd_word[2:0] = {overrun, bad_op, !idle};
            default:      rd_word = RST_WORD;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= RST_WORD;
            s_axi_rresp_o   <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_word;
            s_axi_rresp_o   <= rd_ok ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // ************************************************************
    // Phase sequencer
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE:    if (start) state <= ST_DECODE;
                ST_DECODE:  state <= opcode_ok ? ST_READ : ST_IDLE;
                ST_READ:    state <= ST_PROCESS;
                ST_PROCESS: state <= ST_WRITE;
                ST_WRITE:   state <= ST_IDLE;
                default:    state <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Datapath
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            instr   <= RST_INSTR;
            ea      <= '0;
            dest    <= 1'b0;
            operand <= RST_BYTE;
            result  <= RST_BYTE;
        end else begin
            if (start) begin
                instr <= 16'(merge_strb({16'h0000, instr}, wdata_q, wstrb_q));
            end
            if (state == ST_DECODE) begin
                ea   <= eff_addr(instr[7:0], instr[ACC_BIT], ext_en,
                                 bank_sel, index_base);
                dest <= instr[DEST_BIT];
            end
            if (state == ST_READ) begin
                operand <= mem[ea];
            end
            if (state == ST_PROCESS) begin
                result <= {operand[6:0], status[STS_C]};
            end
        end
    end

    // ************************************************************
    // Software registers and flags
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ext_en     <= 1'b0;
            bank_sel   <= '0;
            index_base <= '0;
            mem_addr   <= '0;
        end else begin
            if (wr_sel(wr_fire, awaddr_q, REG_CTRL) && idle) begin
                ext_en <= wstrb_q[0] ? wdata_q[CTRL_EXT] : ext_en;
            end
            if (wr_sel(wr_fire, awaddr_q, REG_BANK) && idle) begin
                bank_sel <= BANK_W'(merge_strb(32'(bank_sel), wdata_q, wstrb_q));
            end
            if (wr_sel(wr_fire, awaddr_q, REG_INDEX) && idle) begin
                index_base <= ADDR_W'(merge_strb(32'(index_base), wdata_q, wstrb_q));
            end
            if (wr_sel(wr_fire, awaddr_q, REG_MEM_ADDR)) begin
                mem_addr <= ADDR_W'(merge_strb(32'(mem_addr), wdata_q, wstrb_q));
            end
        end
    end

    // Sticky errors; a new event outranks the clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bad_op  <= 1'b0;
            overrun <= 1'b0;
        end else begin
            bad_op  <= (state == ST_DECODE && !opcode_ok) || (bad_op
                       && !(wr_sel(wr_fire, awaddr_q, REG_STATE) && wdata_q[STATE_BADOP]
                            && wstrb_q[0]));
            overrun <= (wr_sel(wr_fire, awaddr_q, REG_INSTR) && !idle) || (overrun
                       && !(wr_sel(wr_fire, awaddr_q, REG_STATE) && wdata_q[STATE_OVR]
                            && wstrb_q[0]));
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wreg <= RST_BYTE;
        end else if (state == ST_WRITE && !dest) begin
            wreg <= result;
        end else if (wr_sel(wr_fire, awaddr_q, REG_WREG) && idle) begin
            wreg <= 8'(merge_strb(32'(wreg), wdata_q, wstrb_q));
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status <= RST_BYTE;
        end else if (state == ST_WRITE) begin
            status[STS_C] <= operand[7];
            status[STS_N] <= result[7];
            status[STS_Z] <= result == RST_BYTE;
        end else if (wr_sel(wr_fire, awaddr_q, REG_STATUS) && idle) begin
            status <= 8'(merge_strb(32'(status), wdata_q, wstrb_q));
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= RST_BYTE;
            end
        end else if (state == ST_WRITE && dest) begin
            mem[ea] <= result;
        end else if (wr_sel(wr_fire, awaddr_q, REG_MEM_DATA) && idle) begin
            mem[mem_addr] <= 8'(merge_strb(32'(mem[mem_addr]), wdata_q, wstrb_q));
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_phases;
        state == ST_READ ##1 state == ST_PROCESS ##1 state == ST_WRITE ##1 state == ST_IDLE;
    endsequence

    sequence s_read_process;
        state == ST_READ ##1 state == ST_PROCESS;
    endsequence

    a_four_phases: assert property (state == ST_DECODE && opcode_ok |=> s_phases)
        else $error("phase order broken");
    a_bad_opcode: assert property (state == ST_DECODE && !opcode_ok
        |=> state == ST_IDLE && bad_op)
        else $error("foreign opcode executed");
    a_rotate_value: assert property (s_read_process
        |=> result == {$past(operand[6:0]), $past(status[STS_C])})
        else $error("rotate result wrong");
    a_carry_out: assert property (state == ST_WRITE
        |=> status[STS_C] == $past(operand[7]))
        else $error("carry not taken from bit 7");
    a_flags_nz: assert property (state == ST_WRITE
        |=> status[STS_N] == $past(result[7]) && status[STS_Z] == ($past(result) == 8'h00))
        else $error("negative or zero flag wrong");
    a_other_bits: assert property (state == ST_WRITE
        |=> (status & ~FLAG_MASK) == $past(status & ~FLAG_MASK))
        else $error("unrelated status bits changed");
    a_dest_accum: assert property (state == ST_WRITE && !dest
        |=> wreg == $past(result))
        else $error("accumulator not written");
    a_dest_file: assert property (state == ST_WRITE && dest
        |=> mem[$past(ea)] == $past(result) && $stable(wreg))
        else $error("file write back wrong");
    a_bank_select: assert property (state == ST_READ && instr[ACC_BIT]
        |-> ea == {bank_sel, instr[7:0]})
        else $error("banked address wrong");
    a_indexed_mode: assert property (state == ST_READ && !instr[ACC_BIT] && ext_en
        && instr[7:0] <= IDX_LIMIT |-> ea == ADDR_W'(index_base + ADDR_W'(instr[7:0])))
        else $error("indexed offset address wrong");
    a_quick_bank: assert property (state == ST_READ && !instr[ACC_BIT]
        && !(ext_en && instr[7:0] <= IDX_LIMIT) |-> ea[7:0] == instr[7:0]
        && ea[ADDR_W-1:8] == {BANK_W{instr[7:0] >= ACCESS_SPLIT}})
        else $error("quick-access address wrong");

endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the rotate-left-through-carry unit
`timescale 1ns/1ps
module testbench
    import rlc_pkg::*;
;
    localparam int         AW    = 12;
    localparam logic [7:0] SPLIT = 8'h80;

    logic        core_clk;
    logic        rst;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] seed;
    int          err_count;
    int          check_count;

    rotate_left_via_carry_instr #(
        .ADDR_W      (AW),
        .ACCESS_SPLIT(SPLIT)
    ) i_rotate_left_via_carry_instr (
        .core_clk_i(core_clk), .rst_i(rst),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
    );

    // ************************************************************
    // Clock, checking and closing
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end

    // ************************************************************
    // Bus master tasks
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // ************************************************************
    // Expected values
    // ************************************************************
    function automatic logic [11:0] target(input logic a, input logic ext, input logic [7:0] f,
                                           input logic [3:0] bank, input logic [11:0] idx);
        if (a) return {bank, f};
        if (ext && f <= 8'h5f) return idx + {4'h0, f};
        return {(f < SPLIT) ? 4'h0 : 4'hf, f};
    endfunction

    function automatic logic [7:0] status_exp(input logic [7:0] st, input logic [7:0] op);
        logic [7:0] res;
        res = {op[6:0], st[STS_C]};
        status_exp = st;
        status_exp[STS_C] = op[7];
        status_exp[STS_N] = res[7];
        status_exp[STS_Z] = (res == 8'h00);
    endfunction

    // ************************************************************
    // Test sequence
    // ************************************************************
    logic [7:0]  fc [8] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'h00, 8'hff, 8'h5f, 8'h10};
    logic [5:0]  badop [4] = '{6'b001100, 6'b001111, 6'b101101, 6'b000101};
    logic [31:0] v;
    logic [1:0]  r;
    logic        d_bit, a_bit, ext;
    logic [7:0]  f, op, st, w0, res_exp;
    logic [3:0]  bank;
    logic [11:0] idx, tg;

    initial begin
        rst = 1'b1; awaddr = 8'h00; araddr = 8'h00; awvalid = 1'b0; wvalid = 1'b0;
        bready = 1'b0; arvalid = 1'b0; rready = 1'b0; wdata = 32'h0000_0000; wstrb = 4'hf;
        seed = 32'h0000_ecb2; err_count = 0; check_count = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            d_bit = (i < 8) ? i[0] : seed[0];
            a_bit = (i < 8) ? i[1] : seed[1];
            ext   = (i < 8) ? i[2] : seed[2];
            f     = (i < 8) ? fc[i] : seed[15:8];
            op    = (i < 2) ? {i[0], 7'h00} : seed[23:16];
            bank  = seed[27:24];
            seed  = lfsr(seed);
            idx   = seed[11:0];
            st    = (i < 2) ? 8'h00 : seed[19:12];
            w0    = seed[27:20];
            res_exp = {op[6:0], st[STS_C]};
            tg    = target(a_bit, ext, f, bank, idx);
            wreg(REG_MEM_ADDR, {20'h0_0000, tg});
            wreg(REG_MEM_DATA, {24'h00_0000, op});
            wreg(REG_WREG, {24'h00_0000, w0});
            wreg(REG_STATUS, {24'h00_0000, st});
            wreg(REG_CTRL, {31'h0000_0000, ext});
            wreg(REG_BANK, {28'h000_0000, bank});
            wreg(REG_INDEX, {20'h0_0000, idx});
            wreg(REG_INSTR, {16'h0000, 6'b001101, d_bit, a_bit, f});
            rd(REG_STATE, v, r);
            check("busy during run", {31'h0000_0000, v[STATE_BUSY]}, 32'h0000_0001);
            rd(REG_STATE, v, r);
            check("idle after run", {31'h0000_0000, v[STATE_BUSY]}, 32'h0000_0000);
            rd(REG_WREG, v, r);
            check("accumulator", v, {24'h00_0000, d_bit ? w0 : res_exp});
            rd(REG_MEM_DATA, v, r);
            check("operand byte", v, {24'h00_0000, d_bit ? res_exp : op});
            rd(REG_STATUS, v, r);
            check("status flags", v, {24'h00_0000, status_exp(st, op)});
        end
        $display("rotate scenarios done");
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            wreg(REG_WREG, {24'h00_0000, seed[7:0]});
            wreg(REG_INSTR, {16'h0000, badop[k], seed[17:8]});
            rd(REG_STATE, v, r);
            check("bad opcode flag", v, 32'h0000_0002);
            rd(REG_WREG, v, r);
            check("accumulator kept", v, {24'h00_0000, seed[7:0]});
            wreg(REG_STATE, 32'h0000_0002);
            rd(REG_STATE, v, r);
            check("flag cleared", v, 32'h0000_0000);
        end
        $display("opcode decode done");
        wreg(REG_INSTR, {16'h0000, 6'b001101, 2'b01, 8'h20});
        wreg(REG_INSTR, {16'h0000, 6'b001101, 2'b01, 8'h20});
        rd(REG_STATE, v, r);
        check("overrun flag", v, 32'h0000_0004);
        wreg(REG_STATE, 32'h0000_0004);
        rd(REG_STATE, v, r);
        check("overrun cleared", v, 32'h0000_0000);
        $display("overrun done");
        wr(8'h30, 32'h1234_5678, r);
        check("unmapped write resp", {30'h0000_0000, r}, 32'h0000_0003);
        rd(8'h24, v, r);
        check("unmapped read data", v, 32'h0000_0000);
        check("unmapped read resp", {30'h0000_0000, r}, 32'h0000_0003);
        $display("unmapped access done");
        tally_and_finish();
    end
endmodule
